// ==== hdl/ssm_serial_port.sv ====
// Synchronous serial port: master receive, slave transmit, Wishbone registers
//
// Behaviour
// (RULE_01) Setting single or continuous receive enable starts master reception in clocked mode.
// (RULE_02) Each received bit is sampled at the falling shift clock edge.
// (RULE_03) Single receive takes one word, then clears its enable and stops.
// (RULE_04) Continuous receive keeps taking words until its enable is cleared.
// (RULE_05) With both enables set, continuous reception wins.
// (RULE_06) Finished word moves to queue if room; a completed move sets receive flag.
// (RULE_07) Receive interrupt requires receive flag and its enable bit.
// (RULE_08) Receive flag is read only; it clears when the queue is empty.
// (RULE_09) Receive queue holds two words while a third shifts in.
// (RULE_10) Word finishing into a full queue sets overrun and is discarded.
// (RULE_11) Overrun clears only when software clears continuous receive enable; the code clears it in any cycle that enable is low and no overrun is being set.
// (RULE_12) Overrun blocks all moves from shifter into queue.
// (RULE_13) Ninth bit and framing flag travel with each word; read pops next entry.
// (RULE_14) Software sets divisor and mode bits before enabling reception.
// (RULE_15) Dropping both receive enables or port enable resets the receiver.
// (RULE_16) Clearing clock source select makes the port a slave on the external clock.
// (RULE_17) Slave mode keeps shifting on the external clock during sleep.
// (RULE_18) With two words written, first loads shifter at once; transmit flag stays clear.
// (RULE_19) When first word ends, second loads, transmit flag sets, interrupt may wake.
// (RULE_20) Software sets up slave mode, loads data, then sets transmit enable.
// (RULE_21) Writing holding register before transmit enable starts the word sooner.
// (RULE_22) Clearing port enable or transmit enable resets the transmitter.
// (RULE_23) With clock source select set the port drives the shift clock.
// (RULE_24) Clocked mode is half duplex: reception and transmission exclude each other.
// (RULE_25) Transmit bits change at the rising shift clock edge.
// (RULE_26) In slave mode shifters advance only on external clock edges.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_serial_port #(
    parameter int DIV_W = 8
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        clockLineIn,
    output logic             clockLineOut,
    output logic             clockLineOe,
    input  wire logic        dataLineIn,
    output logic             dataLineOut,
    output logic             dataLineOe,
    output logic             irqReq
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic clkS1_r, clkS2_r, clkS3_r, datS1_r, datS2_r;
    always_ff @(posedge clock) begin
        clkS1_r <= clockLineIn;
        clkS2_r <= clkS1_r;
        clkS3_r <= clkS2_r;
        datS1_r <= dataLineIn;
        datS2_r <= datS1_r;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:4]       rcCtl_r;
    logic [7:0]       txCtl_r;
    logic [1:0]       enab_r;
    logic [7:0]       thr_r;
    logic             thrFull_r;
    logic [DIV_W-1:0] baud_r;
    logic             ackR_r;
    logic [31:0]      datO_r;
    logic             overrun_error_r;
    logic             txLoad;

    wire [5:0] regIdx   = wb_adr_i[7:2];
    wire       wbReq    = wb_cyc_i & wb_stb_i;
    wire       wbDone   = wbReq & ackR_r;
    wire       wrLow    = wbDone & wb_we_i & wb_sel_i[0];
    wire       rdData   = wbDone & !wb_we_i & (regIdx == `SSM_IDX_RXDATA);
    wire [7:0] wd       = wb_dat_i[7:0];
    wire       serial_port_enable     = rcCtl_r[`SSM_RC_SERIAL_PORT_ENABLE];
    wire       rx9      = rcCtl_r[`SSM_RC_RX9];
    wire       single_receive_enable     = rcCtl_r[`SSM_RC_SINGLE_RECEIVE_ENABLE];
    wire       continuous_receive_enable     = rcCtl_r[`SSM_RC_CONTINUOUS_RECEIVE_ENABLE];
    wire       clock_source_select     = txCtl_r[`SSM_TX_CLOCK_SOURCE_SELECT];
    wire       transmit_enable     = txCtl_r[`SSM_TX_TRANSMIT_ENABLE];
    wire       syncMode = txCtl_r[`SSM_TX_SYNC];
    wire       portOn   = serial_port_enable & syncMode;

    // ----------------------------------------------------------------
    // Receive queue
    // ----------------------------------------------------------------
    ssm_pkg::ssm_entry_t fifo_r [2];
    logic       head_r;
    logic [1:0] cnt_r;
    logic       push;
    logic       srenClr;
    ssm_pkg::ssm_entry_t pushWord;

    wire        pop     = rdData & (cnt_r != 2'h0);
    wire        tailIdx = head_r ^ cnt_r[0];
    wire        receive_flag    = (cnt_r != 2'h0);                            // RULE_08
    wire ssm_pkg::ssm_entry_t headWord = fifo_r[head_r];               // RULE_13

    always_ff @(posedge clock) begin
        if (!rstn) begin
            head_r <= 1'b0;
            cnt_r  <= 2'h0;
        end else begin
            if (push)
                fifo_r[tailIdx] <= pushWord;                           // RULE_09
            if (pop)
                head_r <= !head_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};               // RULE_08
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rcCtl_r   <= 4'h0;
            txCtl_r   <= `SSM_CTRL_RST;
            enab_r    <= 2'h0;
            thr_r     <= 8'h00;
            thrFull_r <= 1'b0;
            baud_r    <= '0;
        end else begin
            if (wrLow && regIdx == `SSM_IDX_RECEIVE_STATUS_CONTROL)
                rcCtl_r <= wd[7:4];
            else if (srenClr)
                rcCtl_r[`SSM_RC_SINGLE_RECEIVE_ENABLE] <= 1'b0;                         // RULE_03
            if (wrLow && regIdx == `SSM_IDX_TRANSMIT_STATUS_CONTROL) begin
                txCtl_r[7:4] <= wd[7:4];
                txCtl_r[0]   <= wd[0];
            end
            if (wrLow && regIdx == `SSM_IDX_ENABLES)
                enab_r <= wd[1:0];
            if (wrLow && regIdx == `SSM_IDX_BAUD)
                baud_r <= wd[DIV_W-1:0];
            if (wrLow && regIdx == `SSM_IDX_TXHOLD) begin
                thr_r     <= wd;
                thrFull_r <= 1'b1;
            end else if (txLoad) begin
                thrFull_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wishbone answer, one wait state
    // ----------------------------------------------------------------
    logic [7:0] rdMux;
    logic       txBusy_r;
    always_comb begin
        rdMux = 8'h00;
        unique case (regIdx)
            `SSM_IDX_RECEIVE_STATUS_CONTROL:   rdMux = {rcCtl_r, 1'b0, headWord[9], overrun_error_r, headWord[8]};
            `SSM_IDX_RXDATA:  rdMux = headWord[7:0];
            `SSM_IDX_TRANSMIT_STATUS_CONTROL:   rdMux = {txCtl_r[7:4], 2'b00, !txBusy_r, txCtl_r[0]};
            `SSM_IDX_FLAGS:   rdMux = {6'h00, !thrFull_r, receive_flag};
            `SSM_IDX_ENABLES: rdMux = {6'h00, enab_r};
            `SSM_IDX_TXHOLD:  rdMux = thr_r;
            `SSM_IDX_BAUD:    rdMux = 8'(baud_r);
            default:          rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ackR_r <= 1'b0;
            datO_r <= 32'h0000_0000;
        end else begin
            ackR_r <= wbReq & !ackR_r;
            if (wbReq & !ackR_r)
                datO_r <= {24'h00_0000, rdMux};
        end
    end
    assign wb_ack_o = ackR_r;
    assign wb_dat_o = datO_r;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    wire rxOn   = portOn & (continuous_receive_enable | (single_receive_enable & clock_source_select));                     // RULE_01 RULE_05
    wire txOn   = portOn & transmit_enable & !rxOn;                               // RULE_24
    wire txRst  = !portOn | !transmit_enable;                                     // RULE_22
    wire single = single_receive_enable & !continuous_receive_enable;                                        // RULE_05

    // ----------------------------------------------------------------
    // Master shift clock and edge events
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] baudCnt_r;
    logic             mclk_r;
    wire  mRun  = portOn & clock_source_select & (rxOn | (txOn & txBusy_r));          // RULE_23
    wire  tick  = mRun & (baudCnt_r == '0);
    always_ff @(posedge clock) begin
        if (!rstn || !mRun) begin
            baudCnt_r <= '0;
            mclk_r    <= 1'b0;
        end else begin
            baudCnt_r <= tick ? baud_r : baudCnt_r - 1'b1;
            if (tick)
                mclk_r <= !mclk_r;
        end
    end
    wire extRise = clkS2_r & !clkS3_r;
    wire extFall = !clkS2_r & clkS3_r;
    wire riseEv  = clock_source_select ? (tick & !mclk_r) : extRise;                  // RULE_16 RULE_26
    wire fallEv  = clock_source_select ? (tick & mclk_r) : extFall;                   // RULE_17 RULE_26

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    logic [8:0] rsr_r;
    logic [3:0] rxCnt_r;
    wire  [8:0] rsrNxt  = {datS2_r, rsr_r[8:1]};                       // RULE_02
    wire        rxStep  = rxOn & fallEv;
    wire        lastBit = rxStep & (rxCnt_r == (rx9 ? `SSM_BITS9 : `SSM_BITS8) - 4'h1);
    wire        fits    = (cnt_r != 2'h2) & !overrun_error_r;                   // RULE_12
    wire        ovrSet  = lastBit & (cnt_r == 2'h2) & !overrun_error_r;         // RULE_10
    assign push     = lastBit & fits;                                  // RULE_06
    assign pushWord = {1'b0, rx9 ? rsrNxt : {1'b0, rsrNxt[8:1]}};      // RULE_13
    assign srenClr  = lastBit & single;                                // RULE_03

    always_ff @(posedge clock) begin
        if (!rstn || !rxOn) begin
            rxCnt_r <= 4'h0;                                           // RULE_15
            rsr_r   <= 9'h000;
        end else if (rxStep) begin
            rsr_r   <= rsrNxt;
            rxCnt_r <= lastBit ? 4'h0 : rxCnt_r + 4'h1;                // RULE_04
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn)
            overrun_error_r <= 1'b0;
        else if (ovrSet)
            overrun_error_r <= 1'b1;                                            // RULE_10
        else if (!continuous_receive_enable)
            overrun_error_r <= 1'b0;                                            // RULE_11
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    logic [8:0] tsr_r;
    logic [3:0] txLeft_r;
    logic       dout_r;
    ssm_pkg::ssm_tx_state_t txSt_r;
    assign txBusy_r = (txSt_r != ssm_pkg::SSM_TX_IDLE);
    assign txLoad   = !txRst & !txBusy_r & thrFull_r;                  // RULE_18 RULE_21
    wire   txRise   = txOn & riseEv;
    wire   txFall   = txOn & fallEv;

    always_ff @(posedge clock) begin
        if (!rstn || txRst) begin
            txSt_r   <= ssm_pkg::SSM_TX_IDLE;                          // RULE_22
            txLeft_r <= 4'h0;
            tsr_r    <= 9'h000;
            dout_r   <= 1'b0;
        end else begin
            unique case (txSt_r)
                ssm_pkg::SSM_TX_IDLE: begin
                    if (txLoad) begin
                        tsr_r    <= {txCtl_r[`SSM_TX_TRANSMIT_NINTH_BIT], thr_r};
                        txLeft_r <= txCtl_r[`SSM_TX_TX9] ? `SSM_BITS9 : `SSM_BITS8;
                        txSt_r   <= ssm_pkg::SSM_TX_SHIFT;
                    end
                end
                ssm_pkg::SSM_TX_SHIFT: begin
                    if (txRise) begin
                        dout_r   <= tsr_r[0];                          // RULE_25
                        tsr_r    <= {1'b0, tsr_r[8:1]};
                        txLeft_r <= txLeft_r - 4'h1;
                        if (txLeft_r == 4'h1)
                            txSt_r <= ssm_pkg::SSM_TX_TAIL;
                    end
                end
                ssm_pkg::SSM_TX_TAIL: begin
                    if (txFall)
                        txSt_r <= ssm_pkg::SSM_TX_IDLE;                // RULE_19
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pins and interrupt request
    // ----------------------------------------------------------------
    assign clockLineOut = mclk_r;
    assign clockLineOe  = portOn & clock_source_select;                               // RULE_23
    assign dataLineOut  = dout_r;
    assign dataLineOe   = txOn;                                        // RULE_24
    assign irqReq = (receive_flag & enab_r[`SSM_FL_RX]) |                      // RULE_07
                    (!thrFull_r & enab_r[`SSM_FL_TX]);                 // RULE_19

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_push_on_last: assert property (lastBit && fits |=> cnt_r == $past(cnt_r) + 2'h1 - {1'b0, $past(pop)}) // RULE_06
        else $error("finished word not queued");
    a_irq_rx_gate: assert property (receive_flag && enab_r[0] |-> irqReq) // RULE_07
        else $error("receive irq missing");
    a_flag_empty: assert property (cnt_r == 2'h0 |-> !rdMux[0] || regIdx != `SSM_IDX_FLAGS) // RULE_08
        else $error("receive flag with empty queue");
    a_queue_depth: assert property (cnt_r <= 2'h2) // RULE_09
        else $error("queue beyond two");
    a_overrun_set: assert property (lastBit && cnt_r == 2'h2 && !pop |=> overrun_error_r) // RULE_10
        else $error("overrun not flagged");
    a_overrun_clr: assert property (overrun_error_r && !continuous_receive_enable && !ovrSet |=> !overrun_error_r) // RULE_11
        else $error("overrun not cleared");
    a_overrun_block: assert property (overrun_error_r |-> !push) // RULE_12
        else $error("push during overrun");
    a_single_stop: assert property (srenClr && !wrLow |=> !single_receive_enable) // RULE_03
        else $error("single enable not cleared");
    a_rx_reset: assert property (!rxOn |=> rxCnt_r == 4'h0) // RULE_15
        else $error("receiver not reset");
    a_tx_reset: assert property (txRst |=> !txBusy_r) // RULE_22
        else $error("transmitter not reset");
    a_half_duplex: assert property (rxOn |-> !dataLineOe) // RULE_24
        else $error("drive while receiving");
    a_tx_flag_load: assert property (txLoad && !wrLow |=> !thrFull_r && txBusy_r) // RULE_19
        else $error("holding not moved");
    a_rx_sample: assert property (rxStep |=> rsr_r[8] == $past(datS2_r)) // RULE_02
        else $error("received bit not taken");
    a_single_stops: assert property (srenClr && !wrLow |=> !rxOn) // RULE_03
        else $error("single receive still running");
    a_both_cont: assert property (portOn && continuous_receive_enable && single_receive_enable |-> rxOn && !srenClr) // RULE_05
        else $error("continuous mode lost");
    a_irq_quiet: assert property (!receive_flag && (thrFull_r || !enab_r[1]) |-> !irqReq) // RULE_07
        else $error("spurious irq");
    a_pop_empty: assert property (rdData && cnt_r == 2'h0 && !push |=> cnt_r == 2'h0) // RULE_08
        else $error("pop from empty queue");
    a_overrun_keep: assert property (overrun_error_r && continuous_receive_enable |=> overrun_error_r) // RULE_11
        else $error("overrun dropped early");
    a_pop_next: assert property (pop && cnt_r[1] |=> headWord == $past(fifo_r[!head_r])) // RULE_13
        else $error("queue head not advanced");
    a_slave_clk: assert property (!clock_source_select |-> !clockLineOe) // RULE_16
        else $error("clock driven in slave mode");
    a_hold_waits: assert property (txBusy_r && thrFull_r |=> thrFull_r) // RULE_18
        else $error("second word left holding early");
    a_tx_load_word: assert property (txLoad |=> tsr_r[7:0] == $past(thr_r)) // RULE_18
        else $error("shifter loaded wrong word");
    a_tx_irq: assert property (!thrFull_r && enab_r[1] |-> irqReq) // RULE_19
        else $error("transmit irq missing");
    a_clk_idle: assert property (!mRun |=> !clockLineOut) // RULE_23
        else $error("shift clock not parked");
    a_tx_rise_only: assert property (!txRise && !txRst |=> $stable(dout_r)) // RULE_25
        else $error("data changed off rising edge");
    a_slave_edges: assert property (!clock_source_select && rxStep |-> extFall) // RULE_26
        else $error("slave shift without external edge");
    a_wb_answer: assert property (wbReq && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_wb_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------
    c_rx_word:  cover property (push);
    c_overrun:  cover property (ovrSet);
    c_tx_two:   cover property (txBusy_r && thrFull_r ##[1:400] txLoad);
    c_slave_rx: cover property (!clock_source_select && push);
    c_ovr_clear: cover property (overrun_error_r ##1 !overrun_error_r);
endmodule

// ==== pkg/ssm_defs.svh ====
// Register offsets, field positions and reset values of the serial port
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH
`define SSM_IDX_RECEIVE_STATUS_CONTROL   6'h13
`define SSM_IDX_RXDATA  6'h14
`define SSM_IDX_TRANSMIT_STATUS_CONTROL   6'h15
`define SSM_IDX_FLAGS   6'h16
`define SSM_IDX_ENABLES 6'h17
`define SSM_IDX_TXHOLD  6'h18
`define SSM_IDX_BAUD    6'h19
`define SSM_RC_SERIAL_PORT_ENABLE     7
`define SSM_RC_RX9      6
`define SSM_RC_SINGLE_RECEIVE_ENABLE     5
`define SSM_RC_CONTINUOUS_RECEIVE_ENABLE     4
`define SSM_RC_FRAMING_ERROR     2
`define SSM_RC_OVERRUN_ERROR     1
`define SSM_RC_RECEIVED_NINTH_BIT     0
`define SSM_TX_CLOCK_SOURCE_SELECT     7
`define SSM_TX_TX9      6
`define SSM_TX_TRANSMIT_ENABLE     5
`define SSM_TX_SYNC     4
`define SSM_TX_SHIFTER_EMPTY     1
`define SSM_TX_TRANSMIT_NINTH_BIT     0
`define SSM_FL_RX       0
`define SSM_FL_TX       1
`define SSM_FLAGS_RST   8'h02
`define SSM_ENAB_RST    8'h00
`define SSM_CTRL_RST    8'h00
`define SSM_BITS8       4'h8
`define SSM_BITS9       4'h9
`endif

// ==== pkg/ssm_pkg.sv ====
// Types shared by the serial port
package ssm_pkg;
    typedef enum logic [1:0] {SSM_TX_IDLE, SSM_TX_SHIFT, SSM_TX_TAIL} ssm_tx_state_t;
    typedef logic [9:0] ssm_entry_t;
endpackage

// ==== tb/ssm_peer_model.sv ====
// Far-side serial peer: feeds bits on the shift clock, or clocks words out of the port
`timescale 1ns/1ps
module ssm_peer_model (
    input  wire logic clkWire,
    input  wire logic dataWire,
    output logic      peerClk,
    output logic      peerData,
    output logic      peerDataOe
);
    bit bitQ[$];

    initial begin
        peerClk = 1'b0;
        peerData = 1'b0;
        peerDataOe = 1'b0;
    end

    // --------------------------------------------------------------
    // Sender: next bit leaves at the rising edge, steady at the fall
    // --------------------------------------------------------------
    always @(posedge clkWire) begin
        if (bitQ.size() > 0) begin
            peerData <= bitQ.pop_front();
            peerDataOe <= 1'b1;
        end else begin
            peerDataOe <= 1'b0;
        end
    end

    // Queue one word, least significant bit first
    task automatic load(input logic [8:0] value, input int nBits);
        for (int i = 0; i < nBits; i++) begin
            bitQ.push_back(value[i]);
        end
    endtask

    task automatic flush();
        bitQ.delete();
    endtask

    // --------------------------------------------------------------
    // Clock source: 80 ns per bit, idle low between words
    // --------------------------------------------------------------
    task automatic clockOut(input int nBits, output logic [7:0] got);
        got = 8'h00;
        #3;
        for (int i = 0; i < nBits; i++) begin
            #40 peerClk = 1'b1;
            #40 peerClk = 1'b0;
            got[i] = dataWire;
        end
    endtask
endmodule

// ==== tb/ssm_serial_port_tb_top.sv ====
// Testbench: register sequences over Wishbone with the serial peer on the link
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_serial_port_tb_top;
    logic        clock;
    logic        rstn;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        clockLineOut;
    logic        clockLineOe;
    logic        dataLineOut;
    logic        dataLineOe;
    logic        irqReq;
    logic        peerClk;
    logic        peerData;
    logic        peerDataOe;
    logic        floatVal;
    logic        clkWire;
    logic        dataWire;
    int          errors;
    int          cmp_count;

    // Undriven data line shows a toggling pattern
    assign clkWire = clockLineOe ? clockLineOut : peerClk;
    assign dataWire = dataLineOe ? dataLineOut : (peerDataOe ? peerData : floatVal);

    ssm_serial_port u_ssm_serial_port (
        .clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .clockLineIn(clkWire), .clockLineOut(clockLineOut),
        .clockLineOe(clockLineOe), .dataLineIn(dataWire), .dataLineOut(dataLineOut),
        .dataLineOe(dataLineOe), .irqReq(irqReq)
    );

    ssm_peer_model u_ssm_peer_model (
        .clkWire(clkWire), .dataWire(dataWire), .peerClk(peerClk),
        .peerData(peerData), .peerDataOe(peerDataOe)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        floatVal <= ~floatVal;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wbAccess(input logic [5:0] idx, input logic we, input logic [7:0] wdata,
                            output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h00_0000, wdata};
        wbSel <= 4'h1;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("BAD at %0t: got %h expected %h", $time, wbAck, 1'b1);
        end
        rdata = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wbWrite(input logic [5:0] idx, input logic [7:0] wdata);
        logic [7:0] rd;
        wbAccess(idx, 1'b1, wdata, rd);
    endtask

    task automatic rdCheck(input logic [5:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] rd;
        wbAccess(idx, 1'b0, 8'h00, rd);
        check(rd & mask, exp);
    endtask

    task automatic waitBit(input logic [5:0] idx, input int pos);
        logic [7:0] rd;
        int n;
        n = 0;
        do begin
            wbAccess(idx, 1'b0, 8'h00, rd);
            n++;
        end while (rd[pos] !== 1'b1 && n < 500);
        if (rd[pos] !== 1'b1) begin
            errors++;
            $display("BAD at %0t: got %h expected %h", $time, rd[pos], 1'b1);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        errors++;
        $display("BAD at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        results();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] got;
        errors = 0;
        cmp_count = 0;
        floatVal = 1'b0;
        rstn = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h1;
        wbDatI = 32'h0000_0000;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        // Reset values, unmapped and read-only places
        rdCheck(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hFE, 8'h00);
        rdCheck(`SSM_IDX_TRANSMIT_STATUS_CONTROL, 8'hFF, 8'h02);
        rdCheck(`SSM_IDX_FLAGS, 8'hFF, 8'h02);
        rdCheck(`SSM_IDX_ENABLES, 8'hFF, 8'h00);
        wbWrite(6'h3F, 8'hFF);
        rdCheck(6'h3F, 8'hFF, 8'h00);
        wbWrite(`SSM_IDX_FLAGS, 8'h01);
        rdCheck(`SSM_IDX_FLAGS, 8'hFF, 8'h02);
        wbWrite(`SSM_IDX_ENABLES, 8'hFF);
        rdCheck(`SSM_IDX_ENABLES, 8'hFF, 8'h03);
        // Master single receive
        wbWrite(`SSM_IDX_ENABLES, 8'h01);
        wbWrite(`SSM_IDX_BAUD, 8'h03);
        wbWrite(`SSM_IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
        u_ssm_peer_model.load(9'h0A5, 8);
        u_ssm_peer_model.load(9'h03C, 8);
        wbWrite(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hA0);
        check(dataLineOe, 1'b0);
        waitBit(`SSM_IDX_FLAGS, 0);
        check(clockLineOe, 1'b1);
        check(irqReq, 1'b1);
        rdCheck(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hFE, 8'h80);
        repeat (150) @(posedge clock);
        rdCheck(`SSM_IDX_RXDATA, 8'hFF, 8'hA5);
        rdCheck(`SSM_IDX_FLAGS, 8'h01, 8'h00);
        check(irqReq, 1'b0);
        u_ssm_peer_model.flush();
        // Continuous receive, nine bits, overrun
        wbWrite(`SSM_IDX_ENABLES, 8'h00);
        u_ssm_peer_model.load(9'h15A, 9);
        u_ssm_peer_model.load(9'h081, 9);
        u_ssm_peer_model.load(9'h1FF, 9);
        wbWrite(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hF0);
        waitBit(`SSM_IDX_RECEIVE_STATUS_CONTROL, 1);
        check(irqReq, 1'b0);
        rdCheck(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hD7, 8'hD3);
        rdCheck(`SSM_IDX_RXDATA, 8'hFF, 8'h5A);
        rdCheck(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hD7, 8'hD2);
        rdCheck(`SSM_IDX_RXDATA, 8'hFF, 8'h81);
        repeat (200) @(posedge clock);
        rdCheck(`SSM_IDX_FLAGS, 8'h01, 8'h00);
        wbWrite(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        rdCheck(`SSM_IDX_RECEIVE_STATUS_CONTROL, 8'hFE, 8'h80);
        u_ssm_peer_model.flush();
        // Slave transmit, two words queued
        wbWrite(`SSM_IDX_ENABLES, 8'h02);
        wbWrite(`SSM_IDX_TXHOLD, 8'h3C);
        wbWrite(`SSM_IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
        rdCheck(`SSM_IDX_FLAGS, 8'hFF, 8'h02);
        rdCheck(`SSM_IDX_TRANSMIT_STATUS_CONTROL, 8'hFF, 8'h30);
        wbWrite(`SSM_IDX_TXHOLD, 8'hC3);
        rdCheck(`SSM_IDX_FLAGS, 8'hFF, 8'h00);
        check(irqReq, 1'b0);
        check(clockLineOe, 1'b0);
        check(dataLineOe, 1'b1);
        u_ssm_peer_model.clockOut(8, got);
        check(got, 8'h3C);
        repeat (10) @(posedge clock);
        rdCheck(`SSM_IDX_FLAGS, 8'hFF, 8'h02);
        check(irqReq, 1'b1);
        u_ssm_peer_model.clockOut(8, got);
        check(got, 8'hC3);
        wbWrite(`SSM_IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
        rdCheck(`SSM_IDX_TRANSMIT_STATUS_CONTROL, 8'hFF, 8'h12);
        check(dataLineOe, 1'b0);
        results();
    end
endmodule
